// ==== core/uart_bit_clock_select.sv ====
// Per-channel bit clock selection and receiver sample timing
`timescale 1ns/1ns
`include "uart_clk_consts.svh"

// Behaviour
// - Receiver clock from select bits 7:4, transmitter from 3:0, decoded independently.
// - Codes 0 to C pick a rate generator output, set by code, rate-set and extend.
// - Code D timer as 16X, E external 16X, F external 1X undivided.
// - Rate-set clear, extend clear: 50 through 38.4K table.
// - Rate-set clear, extend set: 75 through 19.2K table with high rates.
// - Rate-set set, extend clear: 75 through 19.2K table with 2000.
// - Rate-set set, extend set: 50 through 38.4K table with high rates.
// - Rate-set is auxiliary control bit 7, written directly, shared by both channels.
// - Command 08 sets receiver extend bit, 09 clears it.
// - Command 0A sets transmitter extend bit, 0B clears it.
// - Generator rates scale with oscillator frequency, tabulated at 3.6864 MHz.
// - Generator clocks run at 16X; channel divides by 16 for the bit period.
// - With 1X clock the receiver samples once per clock period.
// - 16X receiver takes the start midpoint seven periods after detection.
// - After midpoint the receiver samples every 16 clocks to character end.
// - After the stop bit the receiver waits for a new start bit.
// - Channel A external clocks: transmitter from input 3, receiver from input 4.
// - Timer square wave is used as a 16X clock.
module uart_bit_clock_select (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// External clock inputs
	input wire logic gpInput3,
	input wire logic gpInput4,
	input wire logic extTxClkB,
	input wire logic extRxClkB,
	input wire logic ctSquare,
	// Serial receive lines, index 0 channel A
	input wire logic [1:0] rxSerial,
	// Channel timing outputs
	output logic [1:0] txBitTick,
	output logic [1:0] rxSampleTick,
	output logic [1:0] rxSampleBit,
	output logic [1:0] rxStartMid
);
	import uart_clk_pkg::*;

	// ==========================================
	// Decode helpers
	function automatic clkSrc_t srcOf(input logic [3:0] code);
		clkSrc_t s;
		s = SRC_RATE;
		case (code)
			`CODE_TIMER: s = SRC_TIMER;
			`CODE_EXT_16X: s = SRC_EXT16;
			`CODE_EXT_1X: s = SRC_EXT1;
			default: s = SRC_RATE;
		endcase
		return s;
	endfunction

	// Twice the bit rate, so that 134.5 stays whole
	function automatic logic [18:0] rate2x(input logic [3:0] code, input logic rs,
		input logic x);
		logic [18:0] r;
		r = 19'h0;
		case (code)
			4'h0: r = (rs ^ x) ? 19'h96 : 19'h64;
			4'h1: r = 19'hdc;
			4'h2: r = 19'h10d;
			4'h3: r = (rs ^ x) ? 19'h12c : 19'h190;
			4'h4: r = x ? 19'h1c20 : 19'h258;
			4'h5: r = x ? 19'h7080 : 19'h4b0;
			4'h6: r = x ? 19'he100 : 19'h960;
			4'h7: r = x ? 19'h1c200 : (rs ? 19'hfa0 : 19'h834);
			4'h8: r = x ? 19'h38400 : 19'h12c0;
			4'h9: r = 19'h2580;
			4'ha: r = (rs ^ x) ? 19'he10 : 19'h3840;
			4'hb: r = 19'h4b00;
			4'hc: r = (rs ^ x) ? 19'h9600 : 19'h12c00;
			default: r = 19'h0;
		endcase
		return r;
	endfunction

	// ==========================================
	// Register bus
	clkSel_t selA_q;
	clkSel_t selB_q;
	logic [7:0] aux_q;
	logic [7:0] frameLen_q;
	logic [1:0] rxExt_q;
	logic [1:0] txExt_q;
	clkStatus_t status;
	logic wrEn;
	logic [7:0] wrByte;
	logic [31:0] rdData;
	logic rateSet;
	rxState_t rxState_q [2];

	assign wrEn = ce && cyc_i && stb_i && we_i && ack_o && sel_i[0];
	assign wrByte = dat_i[7:0];
	assign rateSet = aux_q[`RATE_SET_POS];

	always_comb begin
		status.rateSet = rateSet;
		status.rxExt = rxExt_q;
		status.txExt = txExt_q;
		status.rxBusy[0] = rxState_q[0] != RX_IDLE;
		status.rxBusy[1] = rxState_q[1] != RX_IDLE;
		case (adr_i)
			`ADR_AUXILIARY_CONTROL: rdData = {24'h0, aux_q};
			`ADR_FRAME_LENGTH: rdData = {24'h0, frameLen_q};
			`ADR_CLOCK_STATUS: rdData = {25'h0, status};
			default: rdData = 32'h0;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else if (ce) begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= (cyc_i && stb_i && !ack_o && !we_i) ? rdData : 32'h0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			selA_q <= `RESET_CLOCK_SELECT;
			selB_q <= `RESET_CLOCK_SELECT;
			aux_q <= `RESET_AUXILIARY;
			frameLen_q <= `RESET_FRAME_LENGTH;
		end else if (wrEn) begin
			case (adr_i)
				`ADR_CLOCK_SELECT_A: selA_q <= wrByte;
				`ADR_CLOCK_SELECT_B: selB_q <= wrByte;
				`ADR_AUXILIARY_CONTROL: aux_q <= wrByte;
				`ADR_FRAME_LENGTH: frameLen_q <= wrByte;
				default: frameLen_q <= frameLen_q;
			endcase
		end
	end

	// Extend bits, one pair per channel
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rxExt_q <= 2'h0;
			txExt_q <= 2'h0;
		end else if (wrEn) begin
			for (int c = 0; c < 2; c++) begin
				if (adr_i == (c == 0 ? `ADR_COMMAND_REG_A : `ADR_COMMAND_REG_B)) begin
					case (wrByte)
						`CMD_RX_EXT_SET: rxExt_q[c] <= 1'b1;
						`CMD_RX_EXT_CLR: rxExt_q[c] <= 1'b0;
						`CMD_TX_EXT_SET: txExt_q[c] <= 1'b1;
						`CMD_TX_EXT_CLR: txExt_q[c] <= 1'b0;
						default: txExt_q[c] <= txExt_q[c];
					endcase
				end
			end
		end
	end

	// ==========================================
	// External clock synchronisers
	// Index 0 tx A, 1 rx A, 2 tx B, 3 rx B, 4 timer
	logic [4:0] extIn;
	logic [4:0] extMeta_q;
	logic [4:0] extSync_q;
	logic [4:0] extLast_q;
	logic [4:0] extRise;

	assign extIn = {ctSquare, extRxClkB, extTxClkB, gpInput4, gpInput3};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			extMeta_q <= 5'h0;
			extSync_q <= 5'h0;
			extLast_q <= 5'h0;
		end else if (ce) begin
			extMeta_q <= extIn;
			extSync_q <= extMeta_q;
			extLast_q <= extSync_q;
		end
	end

	assign extRise = extSync_q & ~extLast_q;

	// ==========================================
	// Per-direction source selection
	logic [3:0] dirCode [4];
	logic [3:0] dirExt;
	clkSrc_t dirSrc [4];
	logic [3:0] ncoTick;
	logic [3:0] clk16;
	logic [3:0] edge1x;

	assign dirCode[0] = selA_q.txCode;
	assign dirCode[1] = selA_q.rxCode;
	assign dirCode[2] = selB_q.txCode;
	assign dirCode[3] = selB_q.rxCode;
	assign dirExt = {rxExt_q[1], txExt_q[1], rxExt_q[0], txExt_q[0]};

	for (genvar d = 0; d < 4; d++) begin : g_dir
		assign dirSrc[d] = srcOf(dirCode[d]);

		// Rate tracks mclk linearly
		bit_rate_nco u_nco (
			.mclk(mclk),
			.nrst(nrst),
			.ce(ce),
			.inc({1'b0, rate2x(dirCode[d], rateSet, dirExt[d]), 4'h0}),
			.tick(ncoTick[d])
		);

		always_comb begin
			clk16[d] = 1'b0;
			case (dirSrc[d])
				SRC_RATE: clk16[d] = ncoTick[d];
				SRC_TIMER: clk16[d] = extRise[4];
				SRC_EXT16: clk16[d] = extRise[d];
				default: clk16[d] = 1'b0;
			endcase
		end
		assign edge1x[d] = (dirSrc[d] == SRC_EXT1) && extRise[d];
	end

	// ==========================================
	// Transmitter bit period dividers
	logic [3:0] txDiv_q [2];

	for (genvar c = 0; c < 2; c++) begin : g_tx
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				txDiv_q[c] <= 4'h0;
				txBitTick[c] <= 1'b0;
			end else if (ce) begin
				txBitTick[c] <= edge1x[2*c] || (clk16[2*c] && txDiv_q[c] == `SUB_LAST);
				if (clk16[2*c]) begin
					txDiv_q[c] <= txDiv_q[c] + 4'h1;
				end
			end
		end
	end

	// ==========================================
	// Receiver start search and bit sampling
	logic [3:0] rxSub_q [2];
	logic [3:0] rxBits_q [2];
	logic [3:0] rxLen [2];

	assign rxLen[0] = frameLen_q[`FRAME_LEN_A_LO +: 4];
	assign rxLen[1] = frameLen_q[`FRAME_LEN_B_LO +: 4];

	for (genvar c = 0; c < 2; c++) begin : g_rx
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				rxState_q[c] <= RX_IDLE;
				rxSub_q[c] <= 4'h0;
				rxBits_q[c] <= 4'h0;
				rxSampleTick[c] <= 1'b0;
				rxSampleBit[c] <= 1'b0;
				rxStartMid[c] <= 1'b0;
			end else if (ce) begin
				rxSampleTick[c] <= 1'b0;
				rxStartMid[c] <= 1'b0;
				if (dirSrc[2*c+1] == SRC_EXT1) begin
					rxState_q[c] <= RX_IDLE;
					if (edge1x[2*c+1]) begin
						rxSampleTick[c] <= 1'b1;
						rxSampleBit[c] <= rxSerial[c];
					end
				end else if (clk16[2*c+1]) begin
					case (rxState_q[c])
						RX_IDLE: begin
							if (!rxSerial[c]) begin
								rxState_q[c] <= RX_START;
								rxSub_q[c] <= 4'h0;
							end
						end
						RX_START: begin
							rxSub_q[c] <= rxSub_q[c] + 4'h1;
							if (rxSub_q[c] == `MID_LAST) begin
								if (rxSerial[c]) begin
									rxState_q[c] <= RX_IDLE;
								end else begin
									rxState_q[c] <= RX_DATA;
									rxSub_q[c] <= 4'h0;
									rxBits_q[c] <= 4'h0;
									rxSampleTick[c] <= 1'b1;
									rxSampleBit[c] <= rxSerial[c];
									rxStartMid[c] <= 1'b1;
								end
							end
						end
						RX_DATA: begin
							rxSub_q[c] <= rxSub_q[c] + 4'h1;
							if (rxSub_q[c] == `SUB_LAST) begin
								rxSampleTick[c] <= 1'b1;
								rxSampleBit[c] <= rxSerial[c];
								rxBits_q[c] <= rxBits_q[c] + 4'h1;
								if (rxBits_q[c] + 4'h1 >= rxLen[c]) begin
									rxState_q[c] <= RX_IDLE;
								end
							end
						end
						default: rxState_q[c] <= RX_IDLE;
					endcase
				end
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	logic firstCycle_q;
	logic [4:0] rxGap_q [2];
	logic [4:0] txGap_q [2];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			firstCycle_q <= 1'b1;
		end else begin
			firstCycle_q <= 1'b0;
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_chk
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				rxGap_q[c] <= 5'h0;
				txGap_q[c] <= 5'h0;
			end else if (ce) begin
				if (rxState_q[c] == RX_IDLE) begin
					rxGap_q[c] <= 5'h0;
				end else if (rxSampleTick[c]) begin
					rxGap_q[c] <= {4'h0, clk16[2*c+1]};
				end else if (clk16[2*c+1]) begin
					rxGap_q[c] <= rxGap_q[c] + 5'h1;
				end
				if (txBitTick[c]) begin
					// Divider is kept across a 1X tick, so restart from its count
					txGap_q[c] <= {1'b0, txDiv_q[c]} + {4'h0, clk16[2*c]};
				end else if (clk16[2*c]) begin
					txGap_q[c] <= txGap_q[c] + 5'h1;
				end
			end
		end

		sequence s_cmd(logic [7:0] adr, logic [7:0] code);
			wrEn && adr_i == adr && wrByte == code;
		endsequence

		a_rx_ext_set: assert property (s_cmd(c == 0 ? `ADR_COMMAND_REG_A : `ADR_COMMAND_REG_B,
			`CMD_RX_EXT_SET) |=> rxExt_q[c])
			else $error("receiver extend bit not set by command");
		a_tx_ext_clear: assert property (s_cmd(c == 0 ? `ADR_COMMAND_REG_A : `ADR_COMMAND_REG_B,
			`CMD_TX_EXT_CLR) |=> !txExt_q[c])
			else $error("transmitter extend bit not cleared by command");
		a_one_x_sample: assert property (ce && dirSrc[2*c+1] == SRC_EXT1 && extRise[2*c+1]
			|=> rxSampleTick[c] && rxState_q[c] == RX_IDLE)
			else $error("1X edge did not give one receiver sample");
		a_start_mid_gap: assert property (rxStartMid[c] |-> rxGap_q[c] == `MID_GAP)
			else $error("start midpoint not seven 16X periods after detection");
		a_bit_sample_gap: assert property (rxSampleTick[c] && !rxStartMid[c]
			&& $past(rxState_q[c]) == RX_DATA |-> rxGap_q[c] == `BIT_GAP)
			else $error("receiver samples not sixteen 16X periods apart");
		a_frame_end_idle: assert property ($past(rxState_q[c]) == RX_DATA
			&& rxState_q[c] == RX_IDLE && $past(ce) && $past(dirSrc[2*c+1]) != SRC_EXT1
			|-> rxSampleTick[c] && $past(rxBits_q[c]) + 4'h1 >= rxLen[c])
			else $error("receiver left the frame before its last sample");
		a_tx_bit_div: assert property (txBitTick[c] && !$past(edge1x[2*c])
			&& $past(dirSrc[2*c]) == $past(dirSrc[2*c], 40) |-> txGap_q[c] == `BIT_GAP)
			else $error("transmitter bit period not sixteen 16X periods");
	end

	a_rate_set_write: assert property (wrEn && adr_i == `ADR_AUXILIARY_CONTROL
		|=> rateSet == $past(wrByte[`RATE_SET_POS]))
		else $error("rate-set bit does not follow auxiliary control bit 7");
	a_reset_clear: assert property (firstCycle_q |-> !rateSet && rxExt_q == 2'h0
		&& txExt_q == 2'h0)
		else $error("rate-set or extend bits not clear after reset");

endmodule

// ==== core/uart_clk_consts.svh ====
// Offsets, field positions, reset values and counts of the bit clock selector
`ifndef UART_CLK_CONSTS_SVH
`define UART_CLK_CONSTS_SVH

// ==========================================
// Register byte offsets
`define ADR_CLOCK_SELECT_A 8'h00
`define ADR_CLOCK_SELECT_B 8'h04
`define ADR_AUXILIARY_CONTROL 8'h08
`define ADR_COMMAND_REG_A 8'h0c
`define ADR_COMMAND_REG_B 8'h10
`define ADR_FRAME_LENGTH 8'h14
`define ADR_CLOCK_STATUS 8'h18

// ==========================================
// Field positions
`define RATE_SET_POS 7
`define FRAME_LEN_A_LO 0
`define FRAME_LEN_B_LO 4

// ==========================================
// Reset values
`define RESET_CLOCK_SELECT 8'h00
`define RESET_AUXILIARY 8'h00
`define RESET_FRAME_LENGTH 8'h99

// ==========================================
// Command codes
`define CMD_RX_EXT_SET 8'h08
`define CMD_RX_EXT_CLR 8'h09
`define CMD_TX_EXT_SET 8'h0a
`define CMD_TX_EXT_CLR 8'h0b

// ==========================================
// Source codes of a nibble
`define CODE_LAST_RATE 4'hc
`define CODE_TIMER 4'hd
`define CODE_EXT_16X 4'he
`define CODE_EXT_1X 4'hf

// ==========================================
// Timing counts
`define OSC_REF_MOD 24'h708000
`define SUB_LAST 4'hf
`define MID_LAST 4'h6
`define BIT_GAP 5'h10
`define MID_GAP 5'h07

`endif

// ==== core/uart_clk_pkg.sv ====
// Types shared by the bit clock selector
package uart_clk_pkg;

	// ==========================================
	// Clock select register layout
	typedef struct packed {
		logic [3:0] rxCode;
		logic [3:0] txCode;
	} clkSel_t;

	// ==========================================
	// Status word
	typedef struct packed {
		logic [1:0] rxBusy;
		logic [1:0] txExt;
		logic [1:0] rxExt;
		logic rateSet;
	} clkStatus_t;

	// ==========================================
	// Clock source kinds and receiver states
	typedef enum logic [1:0] {SRC_RATE, SRC_TIMER, SRC_EXT16, SRC_EXT1} clkSrc_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rxState_t;

endpackage

// ==== core/bit_rate_nco.sv ====
// Fractional rate generator producing 16X clock pulses from the oscillator
`timescale 1ns/1ns
`include "uart_clk_consts.svh"

module bit_rate_nco #(
	parameter int ACC_W = 23
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Step per oscillator cycle, twice the 16X rate
	input wire logic [ACC_W:0] inc,
	// One-cycle 16X pulse
	output logic tick
);
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W:0] sum;

	// Exact rate ratio: tick rate is inc divided by twice the reference
	assign sum = {1'b0, acc_q} + inc;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= '0;
			tick <= 1'b0;
		end else if (ce) begin
			if (sum >= `OSC_REF_MOD) begin
				acc_q <= ACC_W'(sum - `OSC_REF_MOD);
				tick <= 1'b1;
			end else begin
				acc_q <= sum[ACC_W-1:0];
				tick <= 1'b0;
			end
		end
	end

endmodule

// ==== test/clock_source.sv ====
// Far-side clock source driving the external and timer clock pins in bursts
`timescale 1ns/1ns

module clock_source (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Burst request
	input wire logic go,
	input wire logic [4:0] pinSel,
	input wire logic [7:0] count,
	input wire logic [3:0] half,
	// Pins and status
	output logic [4:0] pins,
	output logic busy
);
	logic [7:0] left_q;
	logic [3:0] cnt_q;
	logic level_q;

	// ==========================================
	// Square wave of count rises, low between bursts
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			left_q <= 8'h00;
			cnt_q <= 4'h0;
			level_q <= 1'b0;
		end else if (go && left_q == 8'h00) begin
			left_q <= count;
			cnt_q <= 4'h0;
			level_q <= 1'b0;
		end else if (left_q != 8'h00) begin
			if (cnt_q == half) begin
				cnt_q <= 4'h0;
				level_q <= !level_q;
				if (level_q) begin
					left_q <= left_q - 8'h01;
				end
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	assign pins = level_q ? pinSel : 5'h00;
	assign busy = left_q != 8'h00;
endmodule

// ==== test/tb_uart_bit_clock_select.sv ====
// Self-checking bench for the bit clock selector
`timescale 1ns/1ns
`include "uart_clk_consts.svh"

module tb_uart_bit_clock_select;
	import uart_clk_pkg::*;
	// ==========================================
	// Signals
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic go = 1'b0;
	logic ack;
	logic busy;
	logic [7:0] adr = 8'h00;
	logic [7:0] cnt = 8'h00;
	logic [31:0] datI = 32'h0;
	logic [31:0] datO;
	logic [31:0] rd;
	logic [4:0] pins;
	logic [4:0] pinSel = 5'h00;
	logic [3:0] half = 4'h3;
	logic [1:0] rxSerial = 2'b11;
	logic [1:0] txBitTick;
	logic [1:0] rxSampleTick;
	logic [1:0] rxSampleBit;
	logic [1:0] rxStartMid;
	int fails = 0;
	int check_count = 0;
	int cycN = 0;
	int txA = 0;
	int txB = 0;
	int smp = 0;
	int mid = 0;
	int smpB = 0;
	int midB = 0;
	int tA[$];

	always #20 mclk = ~mclk;

	always @(posedge mclk) begin
		cycN <= cycN + 1;
		txA <= txA + int'(txBitTick[0]);
		txB <= txB + int'(txBitTick[1]);
		smp <= smp + int'(rxSampleTick[0]);
		mid <= mid + int'(rxStartMid[0]);
		smpB <= smpB + int'(rxSampleTick[1]);
		midB <= midB + int'(rxStartMid[1]);
		if (txBitTick[0] === 1'b1) begin
			tA.push_back(cycN);
		end
	end

	uart_bit_clock_select DUT (.mclk(mclk), .nrst(nrst), .ce(1'b1), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(datI), .dat_o(datO), .ack_o(ack),
		.gpInput3(pins[0]), .gpInput4(pins[1]), .extTxClkB(pins[2]), .extRxClkB(pins[3]),
		.ctSquare(pins[4]), .rxSerial(rxSerial), .txBitTick(txBitTick),
		.rxSampleTick(rxSampleTick), .rxSampleBit(rxSampleBit), .rxStartMid(rxStartMid));

	clock_source far (.mclk(mclk), .nrst(nrst), .go(go), .pinSel(pinSel), .count(cnt),
		.half(half), .pins(pins), .busy(busy));

	// ==========================================
	// Shared tasks
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tmo;
		fails++;
		$display("[FAIL] %0t wait ran out", $time);
		finish_test();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkNear(input int got, input int exp);
		check_count++;
		if (got < exp - 2 || got > exp + 2) begin
			fails++;
			$display("[FAIL] %0t period %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= {24'h0, d};
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			tmo();
		end
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Rises on the selected pins with the serial line held at a level
	task automatic burst(input logic [4:0] sel, input logic [7:0] n, input logic line);
		int k;
		@(posedge mclk);
		pinSel <= sel;
		cnt <= n;
		rxSerial[0] <= line;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (busy !== 1'b0 && k < 4000);
		if (k >= 4000) begin
			tmo();
		end
		repeat (8) @(posedge mclk);
	endtask

	// ==========================================
	// Scenarios
	task automatic test_regs;
		logic [7:0] cmd[8] = '{8'h08, 8'h0a, 8'h09, 8'h0b, 8'h08, 8'h0a, 8'h09, 8'h0b};
		logic [7:0] st[8] = '{8'h02, 8'h0a, 8'h08, 8'h00, 8'h04, 8'h14, 8'h10, 8'h00};
		wb(1'b0, `ADR_CLOCK_STATUS, 8'h00);
		chk(rd, 32'h0);
		wb(1'b1, `ADR_AUXILIARY_CONTROL, 8'h80);
		wb(1'b0, `ADR_CLOCK_STATUS, 8'h00);
		chk(rd, 32'h1);
		wb(1'b0, `ADR_AUXILIARY_CONTROL, 8'h00);
		chk(rd, 32'h80);
		wb(1'b1, `ADR_AUXILIARY_CONTROL, 8'h7f);
		wb(1'b0, `ADR_CLOCK_STATUS, 8'h00);
		chk(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, i < 4 ? `ADR_COMMAND_REG_A : `ADR_COMMAND_REG_B, cmd[i]);
			wb(1'b0, `ADR_CLOCK_STATUS, 8'h00);
			chk(rd, {24'h0, st[i]});
		end
		wb(1'b1, `ADR_CLOCK_SELECT_A, 8'h3c);
		chk(rd, 32'h0);
		wb(1'b0, 8'h1c, 8'h00);
		chk(rd, 32'h0);
		$display("registers done");
	endtask

	task automatic test_rates;
		logic [3:0] code[8] = '{4'hc, 4'hc, 4'hc, 4'hc, 4'h8, 4'h7, 4'ha, 4'ha};
		logic [1:0] mode[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0, 2'h2};
		int rate[8] = '{38400, 19200, 19200, 38400, 115200, 2000, 7200, 1800};
		int k;
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, `ADR_AUXILIARY_CONTROL, mode[i][1] ? 8'h80 : 8'h00);
			wb(1'b1, `ADR_COMMAND_REG_A, mode[i][0] ? `CMD_TX_EXT_SET : `CMD_TX_EXT_CLR);
			wb(1'b1, `ADR_CLOCK_SELECT_A, clkSel_t'({4'hf, code[i]}));
			tA.delete();
			k = 0;
			while (tA.size() < 6 && k < 20000) begin
				@(posedge mclk);
				k++;
			end
			if (k >= 20000) begin
				tmo();
			end
			chkNear(tA[5] - tA[1], 4 * 3686400 / rate[i]);
		end
		$display("rates done");
	endtask

	task automatic test_ext1x;
		logic [3:0] bits = 4'b1011;
		int n;
		int t;
		wb(1'b1, `ADR_CLOCK_SELECT_A, 8'hff);
		n = smp;
		t = txA;
		burst(5'h01, 8'h03, 1'b1);
		chk(txA - t, 32'h3);
		chk(smp - n, 32'h0);
		for (int k = 0; k < 4; k++) begin
			// Line moves only between 1X edges
			burst(5'h02, 8'h01, bits[k]);
			chk(smp - n, k + 1);
			chk(rxSampleBit[0], bits[k]);
		end
		$display("external 1X done");
	endtask

	task automatic test_ext16x;
		int n;
		int m;
		int t;
		wb(1'b1, `ADR_CLOCK_SELECT_A, 8'hee);
		half <= 4'h1;
		t = txA;
		burst(5'h01, 8'h10, 1'b1);
		chk(txA - t, 32'h1);
		half <= 4'h3;
		n = smp;
		m = mid;
		burst(5'h02, 8'h04, 1'b1);
		chk(mid - m, 32'h0);
		for (int k = 0; k < 8; k++) begin
			burst(5'h02, 8'h01, 1'b0);
			chk(mid - m, k == 7 ? 32'h1 : 32'h0);
		end
		chk(smp - n, 32'h1);
		chk(rxSampleBit[0], 1'b0);
		burst(5'h02, 8'h0f, 1'b1);
		chk(smp - n, 32'h1);
		burst(5'h02, 8'h01, 1'b1);
		chk(smp - n, 32'h2);
		burst(5'h02, 8'h80, 1'b1);
		chk(smp - n, 32'ha);
		burst(5'h02, 8'h20, 1'b1);
		chk(smp - n, 32'ha);
		burst(5'h02, 8'h08, 1'b0);
		chk(mid - m, 32'h2);
		$display("external 16X done");
	endtask

	task automatic test_timer_b;
		int a;
		int b;
		wb(1'b1, `ADR_CLOCK_SELECT_B, 8'hdd);
		a = txA;
		b = txB;
		burst(5'h10, 8'h20, 1'b1);
		chk(txB - b, 32'h2);
		chk(txA - a, 32'h0);
		burst(5'h04, 8'h10, 1'b1);
		chk(txB - b, 32'h2);
		a = smpB;
		b = midB;
		rxSerial[1] <= 1'b0;
		burst(5'h10, 8'h08, 1'b1);
		chk(midB - b, 32'h1);
		chk(smpB - a, 32'h1);
		chk(rxSampleBit[1], 1'b0);
		rxSerial[1] <= 1'b1;
		$display("timer clock done");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		test_regs();
		test_rates();
		test_ext1x();
		test_ext16x();
		test_timer_b();
		finish_test();
	end
endmodule
